// File: logic/uart_mode_status_control.sv
// control and status of an asynchronous serial transceiver
// assumes a 16x baud tick from outside and software-style control bits as ports
// Function
// (R1) software raises power before receive enable, drops receive enable before power
// (R2) a low receive pin when power and receive enable rise starts reception
// (R3) software enables reception only while the receive pin is high
// (R4) both enables low before changing parity select or character length
// (R5) on a LIN bus software keeps parity select at no parity
// (R6) transmit enable low before changing the stop length bit
// (R7) reception always uses one stop bit whatever the stop length setting
// (R8) receive enable low before changing the receive error interrupt mode
// (R9) parity error flag follows the currently selected parity mode
// (R10) only the first stop bit position of a received frame is checked
// (R11) data arriving with an overrun is discarded, not written to the buffer
// (R12) reading the receive error status inserts one bus wait cycle
// (R13) software writes the next byte only while the buffer full flag is 0
// (R14) software reinitialises transmit only after completion and shift flag at 0
// (R15) buffer full flag sits in bit 1 of the transmit status register
// (R16) buffer full sets on a buffer write, clears when the byte enters the shifter
`timescale 1ns/1ps
module uart_mode_status_control
  import uart_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  // operation mode bits
  input  wire logic       i_unit_power_enable,
  input  wire logic       i_transmit_enable_bit,
  input  wire logic       i_receive_enable_bit,
  input  wire logic       i_parity_select_hi,
  input  wire logic       i_parity_select_lo,
  input  wire logic       i_char_length_bit,
  input  wire logic       i_stop_length_bit,
  input  wire logic       i_rx_error_irq_mode,
  // baud rate enable
  input  wire logic       i_baud_tick16,
  // serial line
  input  wire logic       i_serial_receive_pin,
  output logic            o_serial_transmit_pin,
  // transmit buffer write
  input  wire logic       i_tx_write,
  input  wire logic [7:0] i_tx_data,
  // receive buffer and status reads
  input  wire logic       i_rx_read,
  input  wire logic       i_status_read,
  output logic [7:0]      o_receive_buffer_reg,
  output logic [2:0]      o_rx_error_status_reg,
  output logic [1:0]      o_tx_status_reg,
  output logic            o_bus_wait,
  // events
  output logic            o_rx_done_irq,
  output logic            o_rx_error_irq,
  output logic            o_tx_done_irq
);
  rx_link_if link ();

  logic       rx_sync1;
  logic       rx_sync2;
  logic       rx_sync3;
  logic       rx_level;
  logic       rx_full;
  logic       rx_on;
  logic       tx_on;
  logic [1:0] par_mode;
  logic [7:0] tx_buffer;
  logic [7:0] tx_shift;
  logic       tx_par;
  logic [4:0] tx_tick;
  logic [3:0] tx_bits;
  logic       tx_stop2;
  logic       read_pending;
  frame_state_t tx_state;

  assign rx_on    = i_unit_power_enable && i_receive_enable_bit; // R1
  assign tx_on    = i_unit_power_enable && i_transmit_enable_bit;
  assign par_mode = {i_parity_select_hi, i_parity_select_lo};

  assign link.enable      = rx_on;
  assign link.tick        = i_baud_tick16;
  assign link.rxd         = rx_level;
  assign link.char8       = i_char_length_bit;
  assign link.parity_mode = par_mode;

  rx_frame_unit frame_unit (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .link       (link)
  );

  // pin synchroniser; a change counts once stages two and three agree
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_sync1 <= 1'b1;
      rx_sync2 <= 1'b1;
      rx_sync3 <= 1'b1;
      rx_level <= 1'b1;
    end else begin
      rx_sync1 <= i_serial_receive_pin;
      rx_sync2 <= rx_sync1;
      rx_sync3 <= rx_sync2;
      if (rx_sync2 == rx_sync3) begin
        rx_level <= rx_sync3;
      end
    end
  end

  // receive buffer, error flags and events
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_receive_buffer_reg  <= DATA_RESET;
      o_rx_error_status_reg <= ERR_RESET;
      rx_full               <= 1'b0;
      o_rx_done_irq         <= 1'b0;
      o_rx_error_irq        <= 1'b0;
    end else begin
      o_rx_done_irq  <= 1'b0;
      o_rx_error_irq <= 1'b0;
      // flags clear when the waited status read completes; a new frame still wins
      if (o_bus_wait) begin
        o_rx_error_status_reg <= ERR_RESET;
      end
      if (i_rx_read) begin
        rx_full <= 1'b0;
      end
      if (!i_unit_power_enable) begin
        o_rx_error_status_reg <= ERR_RESET;
        rx_full               <= 1'b0;
      end else if (link.done) begin
        o_rx_error_status_reg[ERR_PARITY_BIT]  <= link.parity_err; // R9
        o_rx_error_status_reg[ERR_FRAME_BIT]   <= link.frame_err;
        o_rx_error_status_reg[ERR_OVERRUN_BIT] <= rx_full && !i_rx_read;
        if (rx_full && !i_rx_read) begin
          // overrun: the old byte stays, the new one is dropped
          o_rx_error_status_reg[ERR_OVERRUN_BIT] <= 1'b1; // R11
        end else begin
          o_receive_buffer_reg <= link.data;
          rx_full              <= 1'b1;
        end
        if (link.parity_err || link.frame_err || (rx_full && !i_rx_read)) begin
          // mode bit routes errors to the completion event instead
          o_rx_error_irq <= !i_rx_error_irq_mode;
          o_rx_done_irq  <= i_rx_error_irq_mode;
        end else begin
          o_rx_done_irq <= 1'b1;
        end
      end
    end
  end

  // status read inserts one wait cycle before the data is taken
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_bus_wait   <= 1'b0;
      read_pending <= 1'b0;
    end else begin
      read_pending <= i_status_read && !o_bus_wait && !read_pending;
      o_bus_wait   <= i_status_read && !o_bus_wait && !read_pending; // R12
    end
  end

  // transmit buffer, shifter and flags
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_state              <= ST_IDLE;
      tx_buffer             <= DATA_RESET;
      tx_shift              <= DATA_RESET;
      tx_par                <= 1'b0;
      tx_tick               <= 5'h00;
      tx_bits               <= 4'h0;
      tx_stop2              <= 1'b0;
      o_tx_status_reg       <= TXS_RESET;
      o_serial_transmit_pin <= 1'b1;
      o_tx_done_irq         <= 1'b0;
    end else if (!tx_on) begin
      tx_state              <= ST_IDLE;
      o_tx_status_reg       <= TXS_RESET;
      o_serial_transmit_pin <= 1'b1;
      o_tx_done_irq         <= 1'b0;
    end else begin
      o_tx_done_irq <= 1'b0;
      if (tx_state == ST_IDLE && o_tx_status_reg[TXS_FULL_BIT]) begin
        // byte moves to the shifter; a write in this cycle refills the buffer
        tx_shift <= tx_buffer;
        tx_par   <= parity_bit(tx_buffer, i_char_length_bit, par_mode);
        tx_state <= ST_START;
        tx_tick  <= 5'h00;
        o_tx_status_reg[TXS_FULL_BIT]  <= 1'b0; // R16
        o_tx_status_reg[TXS_SHIFT_BIT] <= 1'b1;
        o_serial_transmit_pin          <= 1'b0;
      end else if (tx_state != ST_IDLE && i_baud_tick16) begin
        tx_tick <= tx_tick + 5'h01;
        if (tx_tick + 5'h01 == TICKS_PER_BIT) begin
          tx_tick <= 5'h00;
          case (tx_state)
            ST_START: begin
              tx_state              <= ST_DATA;
              tx_bits               <= 4'h1;
              o_serial_transmit_pin <= tx_shift[0];
              tx_shift              <= {1'b0, tx_shift[7:1]};
            end
            ST_DATA: begin
              if (tx_bits == (i_char_length_bit ? CHAR_BITS_LONG : CHAR_BITS_SHORT)) begin
                if (par_mode == PAR_NONE) begin
                  tx_state              <= ST_STOP;
                  tx_stop2              <= i_stop_length_bit;
                  o_serial_transmit_pin <= 1'b1;
                end else begin
                  tx_state              <= ST_PARITY;
                  o_serial_transmit_pin <= tx_par;
                end
              end else begin
                tx_bits               <= tx_bits + 4'h1;
                o_serial_transmit_pin <= tx_shift[0];
                tx_shift              <= {1'b0, tx_shift[7:1]};
              end
            end
            ST_PARITY: begin
              tx_state              <= ST_STOP;
              tx_stop2              <= i_stop_length_bit;
              o_serial_transmit_pin <= 1'b1;
            end
            ST_STOP: begin
              if (tx_stop2) begin
                tx_stop2 <= 1'b0;
              end else begin
                // shift flag drops at stop end; completion event only if no byte waits or is written
                tx_state                       <= ST_IDLE;
                o_tx_status_reg[TXS_SHIFT_BIT] <= 1'b0; // R14
                o_tx_done_irq <= !o_tx_status_reg[TXS_FULL_BIT] && !i_tx_write;
              end
            end
            default: tx_state <= ST_IDLE;
          endcase
        end
      end
      // write sets the full flag, winning over the clear above
      if (i_tx_write) begin
        tx_buffer                     <= i_tx_data;
        o_tx_status_reg[TXS_FULL_BIT] <= 1'b1; // R15 R16
      end
    end
  end
endmodule

// File: logic/uart_ctrl_pkg.sv
// constants, types and helpers shared by the serial control block
// assumes a 16x oversampling tick from an external baud generator
package uart_ctrl_pkg;
  localparam logic [4:0] TICKS_PER_BIT  = 5'h10;
  localparam logic [4:0] TICKS_HALF_BIT = 5'h08;
  localparam logic [3:0] CHAR_BITS_LONG  = 4'h8;
  localparam logic [3:0] CHAR_BITS_SHORT = 4'h7;
  // parity select encodings {hi, lo}
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD  = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;
  // field positions
  localparam int ERR_OVERRUN_BIT = 0;
  localparam int ERR_FRAME_BIT   = 1;
  localparam int ERR_PARITY_BIT  = 2;
  localparam int TXS_SHIFT_BIT   = 0;
  localparam int TXS_FULL_BIT    = 1;
  localparam logic [2:0] ERR_RESET = 3'h0;
  localparam logic [1:0] TXS_RESET = 2'h0;
  localparam logic [7:0] DATA_RESET = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_DATA,
    ST_PARITY,
    ST_STOP
  } frame_state_t;

  // expected parity bit for the chosen mode over the active data bits
  function automatic logic parity_bit(input logic [7:0] data, input logic char8,
                                      input logic [1:0] mode);
    logic x;
    x = ^{data[6:0], data[7] & char8};
    case (mode)
      PAR_ODD:  parity_bit = ~x;
      PAR_EVEN: parity_bit = x;
      default:  parity_bit = 1'b0;
    endcase
  endfunction
endpackage

// File: logic/rx_link_if.sv
// carrier between the control block and its receive frame unit
// assumes both ends run on the core clock
`timescale 1ns/1ps
interface rx_link_if;
  logic       enable;
  logic       tick;
  logic       rxd;
  logic       char8;
  logic [1:0] parity_mode;
  logic       done;
  logic [7:0] data;
  logic       parity_err;
  logic       frame_err;
  modport ctrl (output enable, tick, rxd, char8, parity_mode,
                input done, data, parity_err, frame_err);
  modport unit (input enable, tick, rxd, char8, parity_mode,
                output done, data, parity_err, frame_err);
endinterface

// File: logic/rx_frame_unit.sv
// receive frame unit: start detect, data, parity and single stop sampling
// assumes rxd is already synchronised and tick is a one-cycle 16x enable
`timescale 1ns/1ps
module rx_frame_unit
  import uart_ctrl_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  rx_link_if.unit  link
);
  frame_state_t state;
  logic [4:0]   tick_cnt;
  logic [3:0]   bit_cnt;
  logic [7:0]   shift;
  logic         par_seen;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state      <= ST_IDLE;
      tick_cnt   <= 5'h00;
      bit_cnt    <= 4'h0;
      shift      <= DATA_RESET;
      par_seen   <= 1'b0;
      link.done  <= 1'b0;
      link.data  <= DATA_RESET;
      link.parity_err <= 1'b0;
      link.frame_err  <= 1'b0;
    end else begin
      link.done <= 1'b0;
      if (!link.enable) begin
        state <= ST_IDLE;
      end else begin
        case (state)
          // a low level, not an edge, starts a frame: low at enable starts at once
          ST_IDLE: begin
            if (!link.rxd) begin // R2
              state    <= ST_START;
              tick_cnt <= 5'h00;
            end
          end
          ST_START: begin
            if (link.tick) begin
              tick_cnt <= tick_cnt + 5'h01;
              if (tick_cnt + 5'h01 == TICKS_HALF_BIT) begin
                tick_cnt <= 5'h00;
                bit_cnt  <= 4'h0;
                state    <= link.rxd ? ST_IDLE : ST_DATA;
              end
            end
          end
          ST_DATA: begin
            if (link.tick) begin
              tick_cnt <= tick_cnt + 5'h01;
              if (tick_cnt + 5'h01 == TICKS_PER_BIT) begin
                tick_cnt <= 5'h00;
                shift    <= {link.rxd, shift[7:1]};
                bit_cnt  <= bit_cnt + 4'h1;
                if (bit_cnt + 4'h1 == (link.char8 ? CHAR_BITS_LONG : CHAR_BITS_SHORT)) begin
                  state <= (link.parity_mode == PAR_NONE) ? ST_STOP : ST_PARITY;
                end
              end
            end
          end
          ST_PARITY: begin
            if (link.tick) begin
              tick_cnt <= tick_cnt + 5'h01;
              if (tick_cnt + 5'h01 == TICKS_PER_BIT) begin
                tick_cnt <= 5'h00;
                par_seen <= link.rxd;
                state    <= ST_STOP;
              end
            end
          end
          // only the first stop position is checked; the stop length setting is ignored
          ST_STOP: begin
            if (link.tick) begin
              tick_cnt <= tick_cnt + 5'h01;
              if (tick_cnt + 5'h01 == TICKS_PER_BIT) begin // R7 R10
                tick_cnt       <= 5'h00;
                state          <= ST_IDLE;
                link.done      <= 1'b1;
                link.frame_err <= !link.rxd;
                link.data      <= link.char8 ? shift : {1'b0, shift[7:1]};
                link.parity_err <= (link.parity_mode == PAR_ODD ||
                                    link.parity_mode == PAR_EVEN) &&
                                   (par_seen != parity_bit(link.char8 ? shift :
                                    {1'b0, shift[7:1]}, link.char8, link.parity_mode)); // R9
              end
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end
endmodule

// File: testbench/uart_mode_status_control_asserts.sv
// port-level assertions for the serial control block
// assumes it is bound onto the top module and sees one clock domain
`timescale 1ns/1ps
module uart_mode_status_control_asserts
  import uart_ctrl_pkg::*;
(
  // watched ports
  input wire logic       i_core_clk,
  input wire logic       i_rst,
  input wire logic       i_unit_power_enable,
  input wire logic       i_transmit_enable_bit,
  input wire logic       i_parity_select_hi,
  input wire logic       i_tx_write,
  input wire logic       i_status_read,
  input wire logic       o_serial_transmit_pin,
  input wire logic [7:0] o_receive_buffer_reg,
  input wire logic [2:0] o_rx_error_status_reg,
  input wire logic [1:0] o_tx_status_reg,
  input wire logic       o_bus_wait,
  input wire logic       o_rx_done_irq,
  input wire logic       o_rx_error_irq,
  input wire logic       o_tx_done_irq
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  wire full = o_tx_status_reg[TXS_FULL_BIT];
  wire busy = o_tx_status_reg[TXS_SHIFT_BIT];
  sequence s_first_write;
    i_tx_write && i_unit_power_enable && i_transmit_enable_bit && !full && !busy;
  endsequence
  sequence s_load;
    full ##1 (!full && busy && !o_serial_transmit_pin);
  endsequence
  a_first_load: assert property (s_first_write |=> s_load) else $error("byte not loaded");
  a_full_cause: assert property ($rose(full) |-> $past(i_tx_write)) else $error("stray full");
  a_done_idle: assert property (o_tx_done_irq |-> !full) else $error("done with byte");
  a_read_waits: assert property ($rose(i_status_read) |=> o_bus_wait) else $error("no wait");
  a_wait_cause: assert property (o_bus_wait |-> $past(i_status_read)) else $error("stray wait");
  a_wait_single: assert property (o_bus_wait |=> !o_bus_wait) else $error("long wait");
  a_err_clear: assert property (o_bus_wait |=> o_rx_error_status_reg == ERR_RESET)
    else $error("flags kept");
  a_buf_cause: assert property ($changed(o_receive_buffer_reg) |-> o_rx_done_irq || o_rx_error_irq)
    else $error("buffer moved");
  a_ovr_keep: assert property ($rose(o_rx_error_status_reg[ERR_OVERRUN_BIT])
    |-> $stable(o_receive_buffer_reg)) else $error("overrun wrote");
  a_par_mode: assert property ($rose(o_rx_error_status_reg[ERR_PARITY_BIT])
    |-> i_parity_select_hi) else $error("parity flag off mode");
endmodule
bind uart_mode_status_control uart_mode_status_control_asserts i_chk (.*);

// File: testbench/remote_node_model.sv
// remote serial node: sends frames to the receive pin, captures the transmit pin
// assumes the bench tick is the 16x baud enable seen by the block
`timescale 1ns/1ps
module remote_node_model
  import uart_ctrl_pkg::*;
(
  // clock and baud enable
  input  wire logic i_core_clk,
  input  wire logic i_tick,
  // serial line
  input  wire logic i_txd,
  output logic      o_rxd
);
  logic [7:0] got_q[$];
  initial o_rxd = 1'b1;
  task automatic wt(input int k);
    repeat (k) @(posedge i_core_clk iff i_tick);
    #1;
  endtask
  // lsb first; bp and bs corrupt the parity and stop bits on purpose
  task automatic send(input logic [7:0] d, input int n, input logic [1:0] pm,
                      input logic bp, input logic bs);
    logic p;
    p = ^(d & (8'hFF >> (8 - n)));
    p = (pm == PAR_ODD) ? ~p : (pm == PAR_EVEN) ? p : 1'b0;
    wt(1);
    o_rxd = 1'b0;
    wt(16);
    for (int i = 0; i < n; i++) begin
      o_rxd = d[i];
      wt(16);
    end
    if (pm != PAR_NONE) begin
      o_rxd = p ^ bp;
      wt(16);
    end
    o_rxd = ~bs;
    wt(16);
    o_rxd = 1'b1;
  endtask
  // capture only 8-bit frames without parity, sampled mid-bit
  initial forever begin
    @(negedge i_txd);
    wt(8);
    if (!i_txd) begin
      logic [7:0] b;
      for (int i = 0; i < 8; i++) begin
        wt(16);
        b[i] = i_txd;
      end
      got_q.push_back(b);
      wt(16);
    end
  end
endmodule

// File: testbench/uart_mode_status_control_test.sv
// self-checking bench: reception, status reads and back-to-back transmit
// assumes the remote node model drives the receive pin and captures the transmit pin
`timescale 1ns/1ps
module uart_mode_status_control_test;
  import uart_ctrl_pkg::*;
  logic       clk, rst, pwr, txe, rxe, ph, pl, cl, sl, im, tick, wr, rd, srd;
  logic       rxd, txd, bw, rdi, rei, tdi;
  logic [7:0] wd, rbuf, d1;
  logic [2:0] est;
  logic [1:0] tst;
  int         err_count, comparisons, cyc, n_done, n_err, n_tx, k, j;
  logic [7:0] exp_q[$];

  uart_mode_status_control i_dut (
    .i_core_clk(clk), .i_rst(rst), .i_unit_power_enable(pwr),
    .i_transmit_enable_bit(txe), .i_receive_enable_bit(rxe), .i_parity_select_hi(ph),
    .i_parity_select_lo(pl), .i_char_length_bit(cl), .i_stop_length_bit(sl),
    .i_rx_error_irq_mode(im), .i_baud_tick16(tick), .i_serial_receive_pin(rxd),
    .o_serial_transmit_pin(txd), .i_tx_write(wr), .i_tx_data(wd), .i_rx_read(rd),
    .i_status_read(srd), .o_receive_buffer_reg(rbuf), .o_rx_error_status_reg(est),
    .o_tx_status_reg(tst), .o_bus_wait(bw), .o_rx_done_irq(rdi), .o_rx_error_irq(rei),
    .o_tx_done_irq(tdi)
  );
  remote_node_model i_p (.i_core_clk(clk), .i_tick(tick), .i_txd(txd), .o_rxd(rxd));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // tick every other cycle keeps frames short without a constant-high enable
  always @(posedge clk) begin
    #1 tick = ~tick;
  end
  always @(posedge clk) begin
    cyc++;
    n_done += rdi;
    n_err += rei;
    n_tx += tdi;
    if (cyc > 20000) begin
      err_count++;
      conclude();
    end
  end

  task conclude;
    if (err_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cmp_data(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t data %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_stat(input logic [2:0] g, input logic [2:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t status %h exp %h", $time, g, e);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cfg(input logic [1:0] pm, input logic c8, input logic s2, input logic m);
    rxe = 1'b0;
    txe = 1'b0;
    step(1);
    {ph, pl} = pm;
    cl = c8;
    sl = s2;
    im = m;
    step(1);
    rxe = 1'b1;
    txe = 1'b1;
    step(1);
  endtask
  task automatic rd_status(input logic [2:0] e);
    srd = 1'b1;
    step(1);
    cmp_data({7'h00, bw}, 8'h01);
    cmp_stat(est, e);
    step(1);
    srd = 1'b0;
    cmp_stat(est, 3'h0);
    rd = 1'b1;
    step(1);
    rd = 1'b0;
    step(1);
  endtask
  task automatic rx(input logic [7:0] d, input logic [1:0] pm, input logic bp,
                    input logic bs, input logic [2:0] e);
    i_p.send(d, cl ? 8 : 7, pm, bp, bs);
    step(6);
    // a low stop keeps the line low past done and the level start sees a new frame
    if (bs) begin
      rxe = 1'b0;
      step(1);
      rxe = 1'b1;
    end
    cmp_data(rbuf, cl ? d : {1'b0, d[6:0]});
    rd_status(e);
  endtask

  initial begin
    rst = 1'b1;
    {pwr, txe, rxe, ph, pl, sl, im, tick, wr, rd, srd} = '0;
    cl = 1'b1;
    wd = 8'h00;
    void'($urandom(91));
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    cmp_data({txd, est, tst, bw, rdi}, 8'h80);
    pwr = 1'b1;
    step(1);
    for (int m = 0; m < 8; m++) begin
      cfg(2'(m >> 1), m[1], 1'b0, 1'b0);
      rx(8'($urandom), 2'(m >> 1), m[0], 1'b0, {m[0] & m[2], 2'b00});
    end
    cfg(PAR_NONE, 1'b1, 1'b1, 1'b0);
    rx(8'($urandom), PAR_NONE, 1'b0, 1'b1, 3'h2);
    // two stops set: a frame right behind must see one stop, then overrun
    d1 = 8'($urandom);
    i_p.send(d1, 8, PAR_NONE, 1'b0, 1'b0);
    i_p.send(8'($urandom), 8, PAR_NONE, 1'b0, 1'b0);
    step(6);
    cmp_data(rbuf, d1);
    rd_status(3'h1);
    cfg(PAR_EVEN, 1'b1, 1'b0, 1'b1);
    k = n_done;
    j = n_err;
    rx(8'($urandom), PAR_EVEN, 1'b1, 1'b0, 3'h4);
    cmp_data(8'(n_done - k), 8'h01);
    cmp_data(8'(n_err - j), 8'h00);
    cfg(PAR_NONE, 1'b1, 1'b0, 1'b0);
    rxe = 1'b0;
    step(1);
    fork
      rx(8'($urandom), PAR_NONE, 1'b0, 1'b0, 3'h0);
      begin
        // late enough that the synchronised line is already low at enable
        step(10);
        rxe = 1'b1;
      end
    join
    k = n_tx;
    for (int i = 0; i < 3; i++) begin
      wd = 8'($urandom);
      wr = 1'b1;
      exp_q.push_back(wd);
      step(1);
      wr = 1'b0;
      cmp_data({7'h00, tst[TXS_FULL_BIT]}, 8'h01);
      while (tst[TXS_FULL_BIT] !== 1'b0) step(1);
    end
    while (tst !== TXS_RESET) step(1);
    // the done pulse is counted one edge after the flags drop
    step(40);
    cmp_data(8'(n_tx - k), 8'h01);
    cmp_data(8'(i_p.got_q.size()), 8'h03);
    foreach (i_p.got_q[i]) cmp_data(i_p.got_q[i], exp_q[i]);
    conclude();
  end
endmodule
